// >>> rtl/adc_corr_pkg.sv
// constants for the converter correction and transfer channel block
package adc_corr_pkg;
    // register byte offsets
    localparam logic [7:0] OFFSET_ADDR = 8'h00;
    localparam logic [7:0] GAIN_ADDR = 8'h04;
    localparam logic [7:0] START_ADDR = 8'h08;
    localparam logic [7:0] LENGTH_ADDR = 8'h0C;
    localparam logic [7:0] CHCFG_ADDR = 8'h10;
    localparam logic [7:0] WPTR_ADDR = 8'h14;
    localparam logic [7:0] FLAGS_ADDR = 8'h18;
    localparam logic [7:0] MASK_ADDR = 8'h1C;
    localparam logic [7:0] CONV_ADDR = 8'h20;
    localparam logic [7:0] DATA_ADDR = 8'h24;
    // reset values and saturation limits
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [15:0] GAIN_RST = 16'h8000;
    localparam logic [15:0] SAT_HI = 16'h7FFF;
    localparam logic [15:0] SAT_LO = 16'h8000;
    // gain fixed point: one integer bit, fraction below
    localparam int GAIN_FRAC = 15;
    // channel config bits
    localparam int CFG_LAUNCH = 0;
    localparam int CFG_WRAP = 1;
    localparam int CFG_RESET = 2;
    // converter control bits
    localparam int CONV_ENABLE = 0;
    localparam int CONV_PINCFG_LSB = 4;
    localparam int PINCFG_W = 4;
    localparam logic [3:0] PIN_ANALOG = 4'h0;
    // event flag bit positions
    localparam int FLAG_OVF = 0;
    localparam int FLAG_SAT = 1;
    localparam int FLAG_FULL = 2;
    localparam int FLAG_HALF = 3;
    localparam int FLAG_DATA = 4;
    localparam int NFLAGS = 5;
    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_RUN = 2'b01,
        CH_DONE = 2'b11
    } chan_state_e;
endpackage : adc_corr_pkg

// >>> rtl/adc_result_correction_dma.sv
// converter result correction pipeline with a dedicated ram transfer channel
`timescale 1ns/1ps

// Notes on behaviour
// - add signed raw result to 16-bit offset
// - multiply by gain giving 35-bit signed product, shifted down 15 bits
// - clamp product to 7FFF/8000, set saturation flag
// - halve clamped value for final result
// - gain is unsigned, one integer bit
// - reset offset zero, gain 0x8000
// - channel writes each corrected result to ram while running
// - buffer length counts 16-bit samples
// - reset bit clears channel, launch bit starts
// - wrap select: 0 linear, 1 auto-wrap
// - linear stops after length, sets full flag
// - conversion after linear stop sets overflow flag
// - auto-wrap reloads pointer at buffer end
// - half flag lower half, full flag upper
// - current write pointer readable
// - reference out only enabled and pin analog
// - analog pin reads input as one
// - write one clears flag, zero ignored
// - flag requests interrupt only when masked in
// - sample ready flag on each new result
module adc_result_correction_dma #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // raw conversion results
    input wire logic raw_valid_i,
    input wire logic [15:0] raw_data_i,
    input wire logic ref_pin_digital_i,
    // ram write port
    output logic ram_we_o,
    output logic [ADDR_W-1:0] ram_addr_o,
    output logic [15:0] ram_data_o,
    output logic irq_o,
    output logic converter_enable_o,
    output logic reference_out_pin_o,
    output logic pin_input_value_o
);
    //----------------------------------------
    // registers
    //----------------------------------------
    logic [15:0] offset_reg;
    logic [15:0] gain_reg;
    logic [ADDR_W-1:0] start_reg;
    logic [ADDR_W-1:0] length_reg;
    logic wrap_reg;
    logic [adc_corr_pkg::NFLAGS-1:0] flags_reg;
    logic [adc_corr_pkg::NFLAGS-1:0] mask_reg;
    logic conv_en_reg;
    logic [adc_corr_pkg::PINCFG_W-1:0] pincfg_reg;
    logic [15:0] data_reg;
    adc_corr_pkg::chan_state_e state_reg;
    logic [ADDR_W-1:0] wptr_reg;
    logic [ADDR_W-1:0] count_reg;
    logic [adc_corr_pkg::NFLAGS-1:0] set_ev;
    logic wr_stb;
    logic rd_stb;
    logic launch_wr;
    logic reset_wr;
    logic pin_analog;

    //----------------------------------------
    // bus decode
    //----------------------------------------
    // a request is taken once: ack high masks the strobe for its second cycle
    assign wr_stb = cyc_i && stb_i && we_i && !ack_o;
    assign rd_stb = cyc_i && stb_i && !we_i && !ack_o;
    assign reset_wr = wr_stb && (adr_i == adc_corr_pkg::CHCFG_ADDR) && sel_i[0]
        && dat_i[adc_corr_pkg::CFG_RESET];
    assign launch_wr = wr_stb && (adr_i == adc_corr_pkg::CHCFG_ADDR) && sel_i[0]
        && dat_i[adc_corr_pkg::CFG_LAUNCH];
    assign pin_analog = (pincfg_reg == adc_corr_pkg::PIN_ANALOG);

    //----------------------------------------
    // correction pipeline
    //----------------------------------------
    // single stage in, one result out per conversion, so order is kept
    logic signed [16:0] sum_s;
    logic signed [34:0] prod_s;
    logic signed [19:0] scaled_s;
    logic [15:0] clamped;
    logic sat;
    logic signed [15:0] final_s;
    logic res_valid_reg;
    logic [15:0] res_reg;
    logic res_sat_reg;

    always_comb begin
        // offset add
        // one extra bit so the sum cannot wrap
        sum_s = $signed({raw_data_i[15], raw_data_i}) + $signed({offset_reg[15], offset_reg});
        // gain unsigned, product
        // kept wide so the clamp sees the true value
        prod_s = 35'($signed(sum_s) * $signed({1'b0, gain_reg}));
        scaled_s = 20'(prod_s >>> adc_corr_pkg::GAIN_FRAC);
        sat = 1'b0;
        clamped = scaled_s[15:0];
        if (scaled_s > $signed({4'h0, adc_corr_pkg::SAT_HI})) begin
            clamped = adc_corr_pkg::SAT_HI;
            sat = 1'b1;
        end else if (scaled_s < -$signed({4'h0, adc_corr_pkg::SAT_LO})) begin
            clamped = adc_corr_pkg::SAT_LO;
            sat = 1'b1;
        end
        final_s = $signed(clamped) >>> 1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_valid_reg <= 1'b0;
            res_reg <= 16'h0000;
            res_sat_reg <= 1'b0;
        end else begin
            // results are dropped while the converter is off
            res_valid_reg <= raw_valid_i && conv_en_reg;
            if (raw_valid_i && conv_en_reg) begin
                res_reg <= final_s;
                res_sat_reg <= sat;
            end
        end
    end

    //----------------------------------------
    // transfer channel
    //----------------------------------------
    logic last_sample;
    logic half_sample;

    // a zero length meets the last sample only once the count reaches all ones: software keeps it nonzero
    // odd lengths put the half mark at the floor of length over two
    assign last_sample = (count_reg == length_reg - ADDR_W'(1));
    assign half_sample = (count_reg == (length_reg >> 1) - ADDR_W'(1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= adc_corr_pkg::CH_IDLE;
            wptr_reg <= '0;
            count_reg <= '0;
            ram_we_o <= 1'b0;
            ram_addr_o <= '0;
            ram_data_o <= 16'h0000;
        end else begin
            ram_we_o <= 1'b0;
            // reset wins when both bits are written together
            if (reset_wr) begin
                state_reg <= adc_corr_pkg::CH_IDLE;
                wptr_reg <= start_reg;
                count_reg <= '0;
            end else if (launch_wr) begin
                state_reg <= adc_corr_pkg::CH_RUN;
                wptr_reg <= start_reg;
                count_reg <= '0;
            end else if (!conv_en_reg && state_reg == adc_corr_pkg::CH_DONE) begin
                // a disabled converter ends a stopped run without overflow
                state_reg <= adc_corr_pkg::CH_IDLE;
            end else if (res_valid_reg && state_reg == adc_corr_pkg::CH_RUN) begin
                ram_we_o <= 1'b1;
                ram_addr_o <= wptr_reg;
                ram_data_o <= res_reg;
                if (last_sample) begin
                    count_reg <= '0;
                    wptr_reg <= start_reg;
                    if (!wrap_reg) begin
                        state_reg <= adc_corr_pkg::CH_DONE;
                    end
                end else begin
                    count_reg <= count_reg + ADDR_W'(1);
                    wptr_reg <= wptr_reg + ADDR_W'(2);
                end
            end
        end
    end

    //----------------------------------------
    // event flags
    //----------------------------------------
    always_comb begin
        set_ev = '0;
        set_ev[adc_corr_pkg::FLAG_DATA] = res_valid_reg;
        set_ev[adc_corr_pkg::FLAG_SAT] = res_valid_reg && res_sat_reg;
        if (res_valid_reg && state_reg == adc_corr_pkg::CH_RUN && !reset_wr && !launch_wr) begin
            // half and full, full on the last sample in both wrap modes
            set_ev[adc_corr_pkg::FLAG_HALF] = half_sample;
            set_ev[adc_corr_pkg::FLAG_FULL] = last_sample;
        end
        set_ev[adc_corr_pkg::FLAG_OVF] = res_valid_reg && conv_en_reg
            && state_reg == adc_corr_pkg::CH_DONE && !reset_wr;
    end

    // write one clears, set wins over clear
    logic flag_wr;
    assign flag_wr = wr_stb && adr_i == adc_corr_pkg::FLAGS_ADDR && sel_i[0];
    for (genvar k = 0; k < adc_corr_pkg::NFLAGS; k++) begin : g_flag
        // an event in the clearing cycle must not be lost
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                flags_reg[k] <= 1'b0;
            end else if (set_ev[k]) begin
                flags_reg[k] <= 1'b1;
            end else if (flag_wr && dat_i[k]) begin
                flags_reg[k] <= 1'b0;
            end
        end
    end

    //----------------------------------------
    // interrupt request
    //----------------------------------------
    // masked interrupt request
    // registered so the request line never glitches on a flag update
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags_reg & mask_reg);
        end
    end

    //----------------------------------------
    // software registers
    //----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            offset_reg <= adc_corr_pkg::OFFSET_RST;
            gain_reg <= adc_corr_pkg::GAIN_RST;
            start_reg <= '0;
            length_reg <= '0;
            wrap_reg <= 1'b0;
            mask_reg <= '0;
            conv_en_reg <= 1'b0;
            pincfg_reg <= '1;
            data_reg <= 16'h0000;
        end else begin
            if (res_valid_reg) begin
                data_reg <= res_reg;
            end
            if (wr_stb) begin
                unique case (adr_i)
                    adc_corr_pkg::OFFSET_ADDR: begin
                        if (sel_i[0]) begin
                            offset_reg[7:0] <= dat_i[7:0];
                        end
                        if (sel_i[1]) begin
                            offset_reg[15:8] <= dat_i[15:8];
                        end
                    end
                    adc_corr_pkg::GAIN_ADDR: begin
                        if (sel_i[0]) begin
                            gain_reg[7:0] <= dat_i[7:0];
                        end
                        if (sel_i[1]) begin
                            gain_reg[15:8] <= dat_i[15:8];
                        end
                    end
                    // low bit forced even
                    // start and length ignore the byte lanes
                    adc_corr_pkg::START_ADDR: start_reg <= {dat_i[ADDR_W-1:1], 1'b0};
                    adc_corr_pkg::LENGTH_ADDR: length_reg <= dat_i[ADDR_W-1:0];
                    adc_corr_pkg::CHCFG_ADDR: begin
                        if (sel_i[0]) begin
                            wrap_reg <= dat_i[adc_corr_pkg::CFG_WRAP];
                        end
                    end
                    adc_corr_pkg::MASK_ADDR: begin
                        if (sel_i[0]) begin
                            mask_reg <= dat_i[adc_corr_pkg::NFLAGS-1:0];
                        end
                    end
                    adc_corr_pkg::CONV_ADDR: begin
                        if (sel_i[0]) begin
                            conv_en_reg <= dat_i[adc_corr_pkg::CONV_ENABLE];
                            pincfg_reg <=
                                dat_i[adc_corr_pkg::CONV_PINCFG_LSB +: adc_corr_pkg::PINCFG_W];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    //----------------------------------------
    // pin outputs
    //----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_enable_o <= 1'b0;
        end else begin
            converter_enable_o <= conv_en_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reference_out_pin_o <= 1'b0;
        end else begin
            reference_out_pin_o <= conv_en_reg && pin_analog;
        end
    end

    // analog pin reads one
    // the digital input is cut off in analog mode, so its level is not looked at
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_input_value_o <= 1'b0;
        end else if (pin_analog) begin
            pin_input_value_o <= 1'b1;
        end else begin
            pin_input_value_o <= ref_pin_digital_i;
        end
    end

    //----------------------------------------
    // bus read and ack
    //----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            // unmapped addresses still answer, reading zero
            ack_o <= wr_stb || rd_stb;
            dat_o <= 32'h0000_0000;
            if (rd_stb) begin
                unique case (adr_i)
                    adc_corr_pkg::OFFSET_ADDR: dat_o <= {16'h0000, offset_reg};
                    adc_corr_pkg::GAIN_ADDR: dat_o <= {16'h0000, gain_reg};
                    adc_corr_pkg::START_ADDR: dat_o <= 32'(start_reg);
                    adc_corr_pkg::LENGTH_ADDR: dat_o <= 32'(length_reg);
                    adc_corr_pkg::CHCFG_ADDR: dat_o <= 32'({wrap_reg, 1'b0});
                    adc_corr_pkg::WPTR_ADDR: dat_o <= 32'(wptr_reg);
                    adc_corr_pkg::FLAGS_ADDR: dat_o <= 32'(flags_reg);
                    adc_corr_pkg::MASK_ADDR: dat_o <= 32'(mask_reg);
                    adc_corr_pkg::CONV_ADDR: dat_o <= 32'({pincfg_reg, 3'b000, conv_en_reg});
                    adc_corr_pkg::DATA_ADDR: dat_o <= {16'h0000, data_reg};
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : adc_result_correction_dma

// >>> testbench/adc_corr_properties.sv
// concurrent checks on the correction and transfer block ports
`timescale 1ns/1ps
module adc_corr_checker #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [31:0] dat_o,
    input wire logic raw_valid_i,
    input wire logic ref_pin_digital_i,
    input wire logic ram_we_o,
    input wire logic [ADDR_W-1:0] ram_addr_o,
    input wire logic [15:0] ram_data_o,
    input wire logic converter_enable_o,
    input wire logic reference_out_pin_o,
    input wire logic pin_input_value_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_pulse;
        ack_o ##1 !ack_o;
    endsequence
    property p_ack; s_req |=> s_pulse; endproperty
    a_ack: assert property (p_ack) else $error("bus answer missing");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    // a write needs an accepted result two edges before
    property p_we_cause; ram_we_o |-> $past(raw_valid_i && converter_enable_o, 2); endproperty
    a_we_cause: assert property (p_we_cause) else $error("ram write without result");
    property p_sign; ram_we_o |-> ram_data_o[15] == ram_data_o[14]; endproperty
    a_sign: assert property (p_sign) else $error("halving lost the sign");
    property p_even; ram_we_o |-> !ram_addr_o[0]; endproperty
    a_even: assert property (p_even) else $error("odd sample address");
    property p_ref; reference_out_pin_o |-> converter_enable_o && pin_input_value_o; endproperty
    a_ref: assert property (p_ref) else $error("reference out while not allowed");
    property p_pin; (!pin_input_value_o && !$past(rst_i)) |-> !$past(ref_pin_digital_i);
    endproperty
    a_pin: assert property (p_pin) else $error("pin input reads low wrongly");
endmodule : adc_corr_checker

// >>> testbench/raw_source_model.sv
// modulator stand-in: one raw result per request, quick or late
`timescale 1ns/1ps
module raw_source_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic slow_i,
    input wire logic [15:0] word_i,
    output logic raw_valid_o,
    output logic [15:0] raw_data_o
);
    logic [2:0] wait_reg;
    logic armed_reg;
    always @(posedge clk_i) begin
        raw_valid_o <= 1'h0;
        // no stale word is left standing between results
        raw_data_o <= ~raw_data_o;
        if (rst_i) begin
            armed_reg <= 1'h0;
            wait_reg <= 3'h0;
            raw_data_o <= 16'h5A5A;
        end else if (fire_i) begin
            armed_reg <= 1'h1;
            wait_reg <= slow_i ? 3'h6 : 3'h0;
        end else if (armed_reg && wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
        end else if (armed_reg) begin
            armed_reg <= 1'h0;
            raw_valid_o <= 1'h1;
            raw_data_o <= word_i;
        end
    end
endmodule : raw_source_model

// >>> testbench/tb_top.sv
// self-checking bench for the correction and transfer block
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc_i = 1'h0;
    logic stb_i = 1'h0;
    logic we_i = 1'h0;
    logic [3:0] sel_i = 4'hF, sel_w = 4'hF;
    logic fire = 1'h0;
    logic slow = 1'h0;
    logic ref_pin_digital_i = 1'h0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o, q;
    logic ack_o, raw_valid_i, ram_we_o, irq_o, converter_enable_o;
    logic reference_out_pin_o, pin_input_value_o;
    logic [15:0] word = 16'h0;
    logic [15:0] raw_data_i, ram_addr_o, ram_data_o, off, gain, wr_addr, wr_data, r;
    logic [16:0] e;
    int num_errors = 0, total_checks = 0, cyc_cnt = 0, wr_cnt = 0, a;
    always #25 clk_i = ~clk_i;
    raw_source_model src_u (.clk_i, .rst_i, .fire_i(fire), .slow_i(slow), .word_i(word),
        .raw_valid_o(raw_valid_i), .raw_data_o(raw_data_i));
    adc_result_correction_dma #(.ADDR_W(16)) dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .raw_valid_i, .raw_data_i,
        .ref_pin_digital_i, .ram_we_o, .ram_addr_o, .ram_data_o, .irq_o,
        .converter_enable_o, .reference_out_pin_o, .pin_input_value_o);
    task automatic tally_and_finish();
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, s, x);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        sel_i <= sel_w;
        adr_i <= ad;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'h1);
        q = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask : wb
    // wide product so the clamp sees the true value
    function automatic logic [16:0] corr(input logic [15:0] raw);
        logic signed [33:0] p;
        logic [15:0] c;
        p = (($signed({raw[15], raw}) + $signed({off[15], off})) * $signed({1'h0, gain})) >>> 15;
        c = (p > 34'sh7FFF) ? 16'h7FFF : (p < -34'sh8000) ? 16'h8000 : p[15:0];
        return {(p > 34'sh7FFF) || (p < -34'sh8000), c[15], c[15:1]};
    endfunction : corr
    task automatic conv(input logic [15:0] raw, input logic [15:0] ad, input logic w);
        int n;
        n = wr_cnt;
        e = corr(raw);
        @(posedge clk_i);
        word <= raw;
        fire <= 1'h1;
        slow <= 1'($urandom_range(0, 1));
        @(posedge clk_i);
        fire <= 1'h0;
        do @(posedge clk_i); while (raw_valid_i !== 1'h1);
        repeat (3) @(posedge clk_i);
        chk(wr_cnt, n + 32'(w));
        if (w) begin
            chk(wr_addr, ad);
            chk(wr_data, e[15:0]);
        end
    endtask : conv
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (ram_we_o === 1'h1) begin
            wr_cnt++;
            wr_addr <= ram_addr_o;
            wr_data <= ram_data_o;
        end
        if (cyc_cnt == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(87151));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, adc_corr_pkg::OFFSET_ADDR, 32'h0);
        chk(q, 32'h0);
        wb(1'h0, adc_corr_pkg::GAIN_ADDR, 32'h0);
        chk(q, 32'h8000);
        sel_w = 4'h1;
        wb(1'h1, adc_corr_pkg::OFFSET_ADDR, 32'hABCD);
        sel_w = 4'hF;
        wb(1'h0, adc_corr_pkg::OFFSET_ADDR, 32'h0);
        chk(q, 32'hCD);
        wb(1'h1, 8'h3C, 32'hFFFF);
        wb(1'h0, 8'h3C, 32'h0);
        chk(q, 32'h0);
        wb(1'h1, adc_corr_pkg::CONV_ADDR, 32'hF1);
        @(negedge clk_i);
        chk(pin_input_value_o, 32'h0);
        chk(reference_out_pin_o, 32'h0);
        wb(1'h1, adc_corr_pkg::CONV_ADDR, 32'h00);
        @(negedge clk_i);
        chk(pin_input_value_o, 32'h1);
        chk(reference_out_pin_o, 32'h0);
        // pins, correction, channel, mask, then start
        off = 16'($urandom_range(0, 32'hFFF) - 32'h800);
        gain = 16'(32'h7000 + $urandom_range(0, 32'h2000));
        wb(1'h1, adc_corr_pkg::OFFSET_ADDR, {16'h0, off});
        wb(1'h1, adc_corr_pkg::GAIN_ADDR, {16'h0, gain});
        wb(1'h1, adc_corr_pkg::START_ADDR, 32'h100);
        wb(1'h1, adc_corr_pkg::LENGTH_ADDR, 32'h4);
        wb(1'h1, adc_corr_pkg::CHCFG_ADDR, 32'h4);
        wb(1'h1, adc_corr_pkg::CHCFG_ADDR, 32'h1);
        wb(1'h1, adc_corr_pkg::MASK_ADDR, 32'h4);
        wb(1'h1, adc_corr_pkg::CONV_ADDR, 32'h01);
        wb(1'h0, adc_corr_pkg::WPTR_ADDR, 32'h0);
        chk(q[15:0], 32'h100);
        chk(reference_out_pin_o, 32'h1);
        for (int i = 0; i < 5; i++) begin
            r = 16'($urandom());
            conv({{3{r[12]}}, r[12:0]}, 16'(32'h100 + 2 * i), i < 4);
            wb(1'h0, adc_corr_pkg::FLAGS_ADDR, 32'h0);
            chk(q[adc_corr_pkg::FLAG_HALF], i > 0);
            chk(q[adc_corr_pkg::FLAG_FULL], i > 2);
            chk(q[adc_corr_pkg::FLAG_OVF], i > 3);
            chk(irq_o, i > 2);
        end
        chk(q[4:0], 32'h1D);
        wb(1'h1, adc_corr_pkg::FLAGS_ADDR, 32'h0);
        wb(1'h0, adc_corr_pkg::FLAGS_ADDR, 32'h0);
        chk(q[4:0], 32'h1D);
        wb(1'h1, adc_corr_pkg::FLAGS_ADDR, 32'h1F);
        wb(1'h0, adc_corr_pkg::DATA_ADDR, 32'h0);
        chk(q[15:0], e[15:0]);
        wb(1'h0, adc_corr_pkg::FLAGS_ADDR, 32'h0);
        chk(q, 32'h0);
        chk(irq_o, 32'h0);
        gain = 16'hFFFF;
        wb(1'h1, adc_corr_pkg::GAIN_ADDR, 32'hFFFF);
        wb(1'h1, adc_corr_pkg::LENGTH_ADDR, 32'h2);
        wb(1'h1, adc_corr_pkg::CHCFG_ADDR, 32'h4);
        wb(1'h1, adc_corr_pkg::CHCFG_ADDR, 32'h3);
        for (int i = 0; i < 6; i++) begin
            // full-scale corners first, so both clamp bounds are met
            r = 16'($urandom());
            r = (i == 0) ? 16'h7000 : (i == 1) ? 16'h9000 : {r[14], r[14:0]};
            // restart mid-run: pointer must go back to the start
            if (i == 3) begin
                wb(1'h1, adc_corr_pkg::CHCFG_ADDR, 32'h4);
                wb(1'h1, adc_corr_pkg::CHCFG_ADDR, 32'h3);
            end
            a = (i < 3) ? i : i - 3;
            conv(r, 16'(32'h100 + 2 * (a % 2)), 1'h1);
        end
        wb(1'h0, adc_corr_pkg::FLAGS_ADDR, 32'h0);
        chk(q[adc_corr_pkg::FLAG_SAT], 32'h1);
        chk(q[adc_corr_pkg::FLAG_OVF], 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
bind adc_result_correction_dma adc_corr_checker #(.ADDR_W(ADDR_W)) prop_u (.clk_i, .rst_i,
    .cyc_i, .stb_i, .ack_o, .dat_o, .raw_valid_i, .ref_pin_digital_i, .ram_we_o, .ram_addr_o,
    .ram_data_o, .converter_enable_o, .reference_out_pin_o, .pin_input_value_o);
